// ---- verilog/csq_pkg.sv ----
// Constants, field layout and decode helpers for the chip-select qualifier.
// Assumes one 40 MHz clock and registers reached over an APB slave.
// Notes on behaviour
// - Direction code 01 reads only, 10 writes only, 11 both, 00 never.
// - Async mode: strobe select 0 follows address strobe, 1 follows data strobe.
// - Async acknowledge codes 0..13 give that many wait states; 1111 leaves it external.
// - Code 1110 ends the access as a two-cycle transfer with internal acknowledge.
// - Space 00 CPU, 01 user, 10 supervisor, 11 supervisor or user.
// - In CPU space the acknowledge level on address bits 3..1 must equal level field.
// - Level field 000 matches any level; 001..111 match only that level.
// - Level field affects chip-select response only, never interrupt recognition.
// - CPU space with autovector enable set makes this block answer with autovector in mode 0 (async) only.
// - Pins assigned as discrete outputs show the matching latch bit.
// - Latch bit 7 ignores writes and reads zero; bits 6..0 read/write.
// - Reset loads latch bits 6..0 with one and bit 7 with zero.
// - Mode 0 async on strobes; mode 1 waits for external bus clock, flags pending.
// - Assert or acknowledge only with base match and every qualifier satisfied, except a chip select assigned as discrete pin, which follows latch bit 0.
// - Synchronous mode ignores the acknowledge field.
package csq_pkg;

  localparam logic [7:0]  ADDR_QUAL        = 8'h00;
  localparam logic [7:0]  ADDR_LATCH       = 8'h04;
  localparam logic [7:0]  ADDR_ASSIGN      = 8'h08;
  localparam logic [7:0]  ADDR_STATUS      = 8'h0c;

  localparam int          MODE_BIT         = 15;
  localparam int          BYTE_LO          = 13;
  localparam int          RW_LO            = 11;
  localparam int          SSEL_BIT         = 10;
  localparam int          ACK_LO           = 6;
  localparam int          SPACE_LO         = 4;
  localparam int          LEVEL_LO         = 1;
  localparam int          AUTOVEC_BIT      = 0;

  localparam logic [15:0] QUAL_RESET       = 16'h0000;
  localparam logic [7:0]  LATCH_RESET      = 8'h7f;
  localparam logic [7:0]  LATCH_USED_MASK  = 8'h7f;
  localparam logic [6:0]  ASSIGN_RESET     = 7'h00;

  localparam logic [1:0]  RW_READ          = 2'h1;
  localparam logic [1:0]  RW_WRITE         = 2'h2;
  localparam logic [1:0]  RW_BOTH          = 2'h3;

  localparam logic [1:0]  SPACE_CPU        = 2'h0;
  localparam logic [1:0]  SPACE_USER       = 2'h1;
  localparam logic [1:0]  SPACE_SUPER      = 2'h2;
  localparam logic [1:0]  SPACE_EITHER     = 2'h3;

  localparam logic [2:0]  LEVEL_ANY        = 3'h0;

  localparam logic [3:0]  ACK_MAX_WAIT     = 4'hd;
  localparam logic [3:0]  ACK_FAST         = 4'he;
  localparam logic [3:0]  ACK_EXTERNAL     = 4'hf;

  localparam logic [4:0]  ACK_BASE_DELAY   = 5'h2;
  localparam logic [7:0]  XCLK_DIV_DEFAULT = 8'h0a;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_XCLK, ST_ACTIVE} csq_state_e;

  function automatic logic csq_dir_hit(input logic [1:0] rw, input logic read_cycle);
    csq_dir_hit = (rw == RW_BOTH) || (rw == RW_READ && read_cycle) ||
                  (rw == RW_WRITE && !read_cycle);
  endfunction

  function automatic logic csq_level_hit(input logic [2:0] want, input logic [2:0] lvl);
    csq_level_hit = (want == LEVEL_ANY) || (want == lvl);
  endfunction

  function automatic logic csq_space_hit(input logic [1:0] field, input logic [1:0] code,
                                         input logic iack, input logic [2:0] want,
                                         input logic [2:0] lvl);
    case (field)
      SPACE_CPU:    csq_space_hit = (code == SPACE_CPU) && iack && csq_level_hit(want, lvl);
      SPACE_USER:   csq_space_hit = (code == SPACE_USER);
      SPACE_SUPER:  csq_space_hit = (code == SPACE_SUPER);
      default:      csq_space_hit = (code == SPACE_USER) || (code == SPACE_SUPER);
    endcase
  endfunction

endpackage

// ---- verilog/csq_ack_if.sv ----
// Start, code, clear and acknowledge between the sequencer and the wait timer.
// Assumes both ends run on the same pclk.
interface csq_ack_if;
  logic       start;
  logic [3:0] code;
  logic       clear;
  logic       ack;
  modport ctrl  (output start, output code, output clear, input ack);
  modport timer (input start, input code, input clear, output ack);
endinterface

// ---- verilog/csq_qualify.sv ----
// Combinational qualifier decode for one chip select.
// Assumes bus cycle inputs are synchronous to pclk and stable during a cycle.
module csq_qualify
  import csq_pkg::*;
(
  input  wire logic [15:0] qual,
  input  wire logic        cycle_valid,
  input  wire logic        base_match,
  input  wire logic        read_cycle,
  input  wire logic [1:0]  space_code,
  input  wire logic        iack_cycle,
  input  wire logic [2:0]  iack_level,
  input  wire logic        address_strobe_pin_n,
  input  wire logic        data_strobe_pin_n,
  output logic             match,
  output logic             strobe_ok
);
  // Level only gates this chip select; nothing here reaches interrupt logic
  always_comb begin
    match = cycle_valid && base_match &&
            csq_dir_hit(qual[RW_LO+:2], read_cycle) &&
            csq_space_hit(qual[SPACE_LO+:2], space_code, iack_cycle,
                          qual[LEVEL_LO+:3], iack_level);
    strobe_ok = qual[SSEL_BIT] ? !data_strobe_pin_n : !address_strobe_pin_n;
  end
endmodule

// ---- verilog/csq_ack_timer.sv ----
// Wait-state counter that produces the internal acknowledge.
// Assumes start is one cycle long and clear arrives when the bus cycle ends.
module csq_ack_timer
  import csq_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  csq_ack_if.timer   ai
);
  logic [4:0] cnt_reg;
  logic       run_reg;
  logic       ack_reg;

  assign ai.ack = ack_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 5'h00;
      run_reg <= 1'b0;
    end else if (ai.clear) begin
      run_reg <= 1'b0;
    end else if (ai.start && ai.code <= ACK_MAX_WAIT) begin
      cnt_reg <= {1'b0, ai.code} + 5'h01;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      if (cnt_reg == 5'h00) begin
        run_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 5'h01;
      end
    end
  end

  // External code never acknowledges here; the partner ends the cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
    end else if (ai.clear) begin
      ack_reg <= 1'b0;
    end else if (ai.start && ai.code == ACK_FAST) begin
      ack_reg <= 1'b1;
    end else if (run_reg && cnt_reg == 5'h00) begin
      ack_reg <= 1'b1;
    end
  end
endmodule

// ---- verilog/csq_top.sv ----
// Chip-select option qualifier with APB register access and discrete pins.
// Assumes bus cycle inputs synchronous to pclk; cycle_valid marks one bus cycle.
//
// The register addresses and the APB slave port are this design's own decisions.
module csq_top
  import csq_pkg::*;
#(
  parameter logic [7:0] XCLK_DIV = XCLK_DIV_DEFAULT
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cycle_valid,
  input  wire logic        base_match,
  input  wire logic        read_cycle,
  input  wire logic [1:0]  space_code,
  input  wire logic        iack_cycle,
  input  wire logic [2:0]  iack_level,
  input  wire logic        address_strobe_pin_n,
  input  wire logic        data_strobe_pin_n,
  output logic             chip_select_n,
  output logic             data_size_ack_n,
  output logic             autovector_n,
  output logic             xclk_pending,
  output logic             external_bus_clock,
  output logic [6:0]       discrete_pins
);
  logic [15:0] qual_reg;
  logic [7:0]  discrete_output_latch_reg;
  logic [6:0]  assign_reg;
  logic [31:0] prdata_reg;
  logic [7:0]  xclk_cnt_reg;
  logic        xclk_tick;
  logic        xclk_level_reg;
  csq_state_e  state_reg;
  csq_state_e  state_next;
  logic        cs_reg_n;
  logic        autovec_reg_n;
  logic        pending_reg;
  logic        match;
  logic        strobe_ok;
  logic        mode_sync;
  logic        autovec_ok;
  logic        wr_access;
  logic        mapped;

  csq_ack_if ack_if ();

  csq_qualify u_qualify (
    .qual                 (qual_reg),
    .cycle_valid          (cycle_valid),
    .base_match           (base_match),
    .read_cycle           (read_cycle),
    .space_code           (space_code),
    .iack_cycle           (iack_cycle),
    .iack_level           (iack_level),
    .address_strobe_pin_n (address_strobe_pin_n),
    .data_strobe_pin_n    (data_strobe_pin_n),
    .match                (match),
    .strobe_ok            (strobe_ok)
  );

  csq_ack_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .ai      (ack_if.timer)
  );

  assign mode_sync = qual_reg[MODE_BIT];
  // Autovector kept off in sync mode: its timing would depend on clock alignment
  assign autovec_ok = (qual_reg[SPACE_LO+:2] == SPACE_CPU) && qual_reg[AUTOVEC_BIT] &&
                      !mode_sync;

  // APB slave: zero wait states, error on unmapped or read-only writes
  assign mapped    = (paddr == ADDR_QUAL) || (paddr == ADDR_LATCH) ||
                     (paddr == ADDR_ASSIGN) || (paddr == ADDR_STATUS);
  assign wr_access = psel && penable && pwrite && mapped && (paddr != ADDR_STATUS);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && (!mapped || (pwrite && paddr == ADDR_STATUS));
  assign prdata    = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_reg <= QUAL_RESET;
    end else if (wr_access && paddr == ADDR_QUAL) begin
      if (pstrb[0]) begin
        qual_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        qual_reg[15:8] <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discrete_output_latch_reg <= LATCH_RESET;
    end else if (wr_access && paddr == ADDR_LATCH && pstrb[0]) begin
      discrete_output_latch_reg <= pwdata[7:0] & LATCH_USED_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      assign_reg <= ASSIGN_RESET;
    end else if (wr_access && paddr == ADDR_ASSIGN && pstrb[0]) begin
      assign_reg <= pwdata[6:0];
    end
  end

  // Read data captured in the setup phase so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_QUAL:   prdata_reg <= {16'h0000, qual_reg};
        ADDR_LATCH:  prdata_reg <= {24'h00_0000, discrete_output_latch_reg};
        ADDR_ASSIGN: prdata_reg <= {25'h000_0000, assign_reg};
        ADDR_STATUS: prdata_reg <= {28'h000_0000, pending_reg, !autovec_reg_n,
                                    ack_if.ack, !cs_reg_n};
        default:     prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // External bus clock from a divider; tick marks its rising edge
  assign xclk_tick = (xclk_cnt_reg == XCLK_DIV - 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xclk_cnt_reg   <= 8'h00;
      xclk_level_reg <= 1'b0;
    end else if (xclk_tick) begin
      xclk_cnt_reg   <= 8'h00;
      xclk_level_reg <= 1'b1;
    end else begin
      xclk_cnt_reg   <= xclk_cnt_reg + 8'h01;
      if (xclk_cnt_reg == {1'b0, XCLK_DIV[7:1]}) begin
        xclk_level_reg <= 1'b0;
      end
    end
  end
  assign external_bus_clock = xclk_level_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (match && mode_sync) begin
          state_next = ST_WAIT_XCLK;
        end else if (match && strobe_ok) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_WAIT_XCLK: begin
        if (!match) begin
          state_next = ST_IDLE;
        end else if (xclk_tick) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!cycle_valid) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_reg_n      <= 1'b1;
      autovec_reg_n <= 1'b1;
      pending_reg   <= 1'b0;
    end else begin
      cs_reg_n      <= (state_next != ST_ACTIVE);
      autovec_reg_n <= !(state_next == ST_ACTIVE && autovec_ok);
      pending_reg   <= (state_next == ST_WAIT_XCLK);
    end
  end

  // Timer only runs for async accesses; sync mode never reads the field
  assign ack_if.start = (state_reg == ST_IDLE) && match && strobe_ok && !mode_sync;
  assign ack_if.code  = qual_reg[ACK_LO+:4];
  assign ack_if.clear = !cycle_valid;

  assign chip_select_n   = assign_reg[0] ? discrete_output_latch_reg[0] : cs_reg_n;
  assign data_size_ack_n = !ack_if.ack;
  assign autovector_n    = autovec_reg_n;
  assign xclk_pending    = pending_reg;
  assign discrete_pins   = (assign_reg & discrete_output_latch_reg[6:0]) | ~assign_reg;

  // Checks
  logic [4:0] active_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_cnt <= 5'h00;
    end else if (state_reg != ST_ACTIVE) begin
      active_cnt <= 5'h00;
    end else if (active_cnt != 5'h1f) begin
      active_cnt <= active_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cs_start;
    $fell(cs_reg_n);
  endsequence

  sequence s_async_start;
    s_cs_start ##0 !mode_sync;
  endsequence

  property p_dir;
    s_cs_start |-> csq_dir_hit($past(qual_reg[RW_LO+:2]), $past(read_cycle));
  endproperty
  a_dir: assert property (p_dir) else $error("chip select on wrong direction");

  property p_strobe;
    s_async_start |-> ($past(qual_reg[SSEL_BIT]) ? !$past(data_strobe_pin_n)
                                                 : !$past(address_strobe_pin_n));
  endproperty
  a_strobe: assert property (p_strobe) else $error("chip select ahead of strobe");

  property p_wait;
    $rose(ack_if.ack) && (qual_reg[ACK_LO+:4] <= ACK_MAX_WAIT) |->
      active_cnt == {1'b0, qual_reg[ACK_LO+:4]} + ACK_BASE_DELAY;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state count wrong");

  property p_fast;
    s_async_start ##0 (qual_reg[ACK_LO+:4] == ACK_FAST) ##0 cycle_valid |=> !data_size_ack_n;
  endproperty
  a_fast: assert property (p_fast) else $error("fast termination late");

  // Fast code acknowledges in the same cycle that the select goes active
  property p_fast_edge;
    s_async_start ##0 (qual_reg[ACK_LO+:4] == ACK_FAST) |-> !data_size_ack_n;
  endproperty
  a_fast_edge: assert property (p_fast_edge) else $error("fast ack not with select");

  property p_space;
    s_cs_start |-> csq_space_hit($past(qual_reg[SPACE_LO+:2]), $past(space_code),
                                 $past(iack_cycle), $past(qual_reg[LEVEL_LO+:3]),
                                 $past(iack_level));
  endproperty
  a_space: assert property (p_space) else $error("chip select in wrong space");

  property p_ext_ack;
    (state_reg == ST_ACTIVE) && (qual_reg[ACK_LO+:4] == ACK_EXTERNAL) |-> data_size_ack_n;
  endproperty
  a_ext_ack: assert property (p_ext_ack) else $error("internal ack on external code");

  property p_autovec;
    $fell(autovec_reg_n) |-> $fell(cs_reg_n) && $past(autovec_ok);
  endproperty
  a_autovec: assert property (p_autovec) else $error("autovector without cpu space");

  property p_autovec_sync;
    !autovec_reg_n |-> !mode_sync;
  endproperty
  a_autovec_sync: assert property (p_autovec_sync) else $error("autovector in sync mode");

  property p_latch;
    discrete_output_latch_reg[7] == 1'b0;
  endproperty
  a_latch: assert property (p_latch) else $error("latch bit 7 set");

  property p_pin;
    assign_reg[0] |-> chip_select_n == discrete_output_latch_reg[0];
  endproperty
  a_pin: assert property (p_pin) else $error("discrete pin not from latch");

  property p_sync;
    (state_reg != ST_IDLE) && mode_sync && $stable(mode_sync) |-> data_size_ack_n;
  endproperty
  a_sync: assert property (p_sync) else $error("ack in synchronous mode");

  property p_pending;
    (state_reg == ST_IDLE) && match && mode_sync |=> xclk_pending;
  endproperty
  a_pending: assert property (p_pending) else $error("pending flag missing");

  property p_xclk_gate;
    s_cs_start ##0 mode_sync |-> $past(xclk_tick) && $past(pending_reg);
  endproperty
  a_xclk_gate: assert property (p_xclk_gate) else $error("sync select off clock");

  property p_end;
    $fell(cycle_valid) |=> cs_reg_n && data_size_ack_n && autovec_reg_n;
  endproperty
  a_end: assert property (p_end) else $error("select held past cycle end");

endmodule

// ---- tb/csq_bus_partner.sv ----
// External bus side: runs one bus cycle and times the block's answers.
// Assumes the bench clock; strobes idle high between cycles.
module csq_bus_partner (
  input  wire logic       pclk,
  output logic            cycle_valid,
  output logic            base_match,
  output logic            read_cycle,
  output logic [1:0]      space_code,
  output logic            iack_cycle,
  output logic [2:0]      iack_level,
  output logic            address_strobe_pin_n,
  output logic            data_strobe_pin_n,
  input  wire logic       chip_select_n,
  input  wire logic       data_size_ack_n,
  input  wire logic       autovector_n,
  input  wire logic       xclk_pending
);
  timeunit 1ns;
  timeprecision 100ps;
  integer pseed = 61;

  // Released lines wander so a stale value cannot fake a match
  task automatic idle();
    logic [31:0] r;
    r = $random(pseed);
    cycle_valid <= 1'b0;
    address_strobe_pin_n <= 1'b1;
    data_strobe_pin_n <= 1'b1;
    {base_match, read_cycle, space_code, iack_cycle, iack_level} <= r[7:0];
  endtask

  initial idle();

  task automatic run(input logic rd, input logic [1:0] sc, input logic [2:0] il,
                     input logic bm, input int hold, output int cs_at, output int ack_at,
                     output int av_at, output int pd_at, output logic clean);
    cs_at = -1;
    ack_at = -1;
    av_at = -1;
    pd_at = -1;
    @(posedge pclk);
    cycle_valid <= 1'b1;
    base_match <= bm;
    read_cycle <= rd;
    space_code <= sc;
    iack_cycle <= (sc == 2'h0);
    iack_level <= il;
    address_strobe_pin_n <= 1'b0;
    for (int k = 1; k <= hold; k++) begin
      @(posedge pclk);
      // Data strobe trails address strobe by two cycles
      if (k == 2) data_strobe_pin_n <= 1'b0;
      #1;
      if (chip_select_n === 1'b0 && cs_at < 0) cs_at = k;
      if (data_size_ack_n === 1'b0 && ack_at < 0) ack_at = k;
      if (autovector_n === 1'b0 && av_at < 0) av_at = k;
      if (xclk_pending === 1'b1 && pd_at < 0) pd_at = k;
    end
    @(posedge pclk);
    idle();
    @(posedge pclk);
    #1;
    clean = chip_select_n & data_size_ack_n & autovector_n;
  endtask
endmodule

// ---- tb/chip_select_option_qualifier_test.sv ----
// Self-checking bench for the chip-select qualifier top.
// Assumes csq_pkg and the bus partner model are compiled first.
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin \
  miscompares++; $display("mismatch %0t %s", $time, msg); end end
module chip_select_option_qualifier_test
  import csq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] DIV = 8'h04;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        cycle_valid, base_match, read_cycle, iack_cycle;
  logic [1:0]  space_code;
  logic [2:0]  iack_level;
  logic        address_strobe_pin_n, data_strobe_pin_n;
  logic        chip_select_n, data_size_ack_n, autovector_n, xclk_pending, bus_clk;
  logic [6:0]  discrete_pins;
  int          miscompares = 0;
  int          n_tests = 0;
  integer      seed = 61;

  csq_top #(.XCLK_DIV(DIV)) u_csq_top (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cycle_valid, .base_match,
    .read_cycle, .space_code, .iack_cycle, .iack_level, .address_strobe_pin_n,
    .data_strobe_pin_n, .chip_select_n, .data_size_ack_n, .autovector_n,
    .xclk_pending, .external_bus_clock(bus_clk), .discrete_pins);

  csq_bus_partner u_csq_bus_partner (.pclk, .cycle_valid, .base_match, .read_cycle,
    .space_code, .iack_cycle, .iack_level, .address_strobe_pin_n, .data_strobe_pin_n,
    .chip_select_n, .data_size_ack_n, .autovector_n, .xclk_pending);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end

  initial begin
    logic [31:0] rd;
    logic        er, cl, ssel, av, rdc, bm, m;
    logic [1:0]  dir, sp, sc;
    logic [2:0]  lv, il;
    logic [3:0]  ack;
    logic [6:0]  lat, asg;
    int          cs_at, ack_at, av_at, pd_at, e_cs, e_ack, e_av;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_QUAL, 32'h0, rd, er);
    `CHK(rd, 32'h0, "qual reset")
    apb(1'b0, ADDR_LATCH, 32'h0, rd, er);
    `CHK(rd, 32'h7f, "latch reset")
    apb(1'b1, ADDR_LATCH, 32'ha5, rd, er);
    apb(1'b0, ADDR_LATCH, 32'h0, rd, er);
    `CHK(rd, 32'h25, "latch bit 7")
    apb(1'b0, 8'h40, 32'h0, rd, er);
    `CHK({er, rd}, 33'h100000000, "unmapped read")
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    `CHK({er, rd}, 33'h0, "status idle")
    for (int i = 0; i < 64; i++) begin
      rd = $random(seed);
      {dir, sp, lv, ssel, av, rdc, bm, il} = rd[13:0];
      ack = i[3:0];
      sc = 2'(($random(seed) & 32'h7fff) % 3);
      // Steer every third cycle at a hit so qualifiers are not always refused
      if (i % 3 == 0) begin
        bm = 1'b1;
        sc = (sp == 2'h3) ? 2'h1 : sp;
        if (lv != 3'h0) il = lv;
      end
      apb(1'b1, ADDR_QUAL, {16'h0, 1'b0, 2'h0, dir, ssel, ack, sp, lv, av}, rd, er);
      u_csq_bus_partner.run(rdc, sc, il, bm, 24, cs_at, ack_at, av_at, pd_at, cl);
      m = bm && (dir == 2'h3 || (dir == 2'h1 && rdc) || (dir == 2'h2 && !rdc));
      case (sp)
        2'h0: m = m && sc == 2'h0 && (lv == 3'h0 || lv == il);
        2'h3: m = m && (sc == 2'h1 || sc == 2'h2);
        default: m = m && sc == sp;
      endcase
      e_cs = !m ? -1 : (ssel ? 3 : 1);
      // Fast code acknowledges together with the select
      e_ack = (!m || ack == 4'hf) ? -1 : (ack == 4'he ? e_cs : e_cs + ack + 2);
      e_av = (m && sp == 2'h0 && av) ? e_cs : -1;
      `CHK(cs_at, e_cs, "chip select timing")
      `CHK(ack_at, e_ack, "acknowledge timing")
      `CHK(av_at, e_av, "autovector")
      `CHK(cl, 1'b1, "negate at cycle end")
    end
    // Autovector left clear: not allowed in synchronous mode
    apb(1'b1, ADDR_QUAL, {16'h0, 1'b1, 2'h0, RW_BOTH, 1'b0, 4'h0, SPACE_USER, 4'h0}, rd, er);
    u_csq_bus_partner.run(1'b1, 2'h1, 3'h0, 1'b1, 14, cs_at, ack_at, av_at, pd_at, cl);
    `CHK(pd_at, 1, "pending flag")
    `CHK(cs_at >= 2 && cs_at <= 2 + DIV, 1'b1, "sync assertion")
    `CHK(ack_at, -1, "sync ignores ack")
    `CHK(cl, 1'b1, "sync negate")
    for (int i = 0; i < 4; i++) begin
      rd = $random(seed);
      {lat, asg} = rd[13:0];
      apb(1'b1, ADDR_ASSIGN, {25'h0, asg}, rd, er);
      apb(1'b1, ADDR_LATCH, {25'h0, lat}, rd, er);
      @(posedge pclk);
      #1;
      `CHK(discrete_pins, (lat & asg) | ~asg, "discrete pins")
      `CHK(chip_select_n, asg[0] ? lat[0] : 1'b1, "discrete chip select")
    end
    // Bus clock has one rising edge per DIV cycles
    ack_at = 0;
    cl = bus_clk;
    repeat (4 * DIV) begin
      @(posedge pclk);
      #1;
      if (bus_clk && !cl) ack_at++;
      cl = bus_clk;
    end
    `CHK(ack_at, 4, "bus clock rate")
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK(discrete_pins, 7'h7f, "pins after reset")
    apb(1'b0, ADDR_LATCH, 32'h0, rd, er);
    `CHK(rd, 32'h7f, "latch after reset")
    print_verdict();
  end
endmodule
